// ---- design/rff_pkg.sv ----
package rff_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned FILTER_TIME_US   = 100;
  localparam int unsigned FILTER_CYCLES    = (FILTER_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_MAX_MS = 100;
  localparam int unsigned RST_PULSE_CYCLES = (RST_PULSE_MAX_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // flag vector layout
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_COUNT        = 12;
  localparam int unsigned BIT_AUX_LOW       = 0;
  localparam int unsigned BIT_AUX_OVERLOAD  = 1;
  localparam int unsigned BIT_BUS_THERMAL   = 2;
  localparam int unsigned BIT_BUS_UNDERVOLT = 3;
  localparam int unsigned BIT_BUS_OVERLOAD  = 4;
  localparam int unsigned BIT_SENSE_LOW     = 5;
  localparam int unsigned BIT_SUPPLY_LOW    = 6;
  localparam int unsigned BIT_MAIN_OVL_NORM = 7;
  localparam int unsigned BIT_MAIN_OVL_LP   = 8;
  localparam int unsigned BIT_MAIN_THERMAL  = 9;
  localparam int unsigned BIT_RST_SHORT     = 10;
  localparam int unsigned BIT_BATTERY_FAIL  = 11;

  localparam logic [11:0] FLAGS_RESET = 12'h000;

endpackage : rff_pkg

// ---- design/rff_sync.sv ----
`timescale 1ns/10ps
module rff_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule : rff_sync

// ---- design/rff_flag_cell.sv ----
`timescale 1ns/10ps
module rff_flag_cell #(
  parameter int unsigned FILTER = 10000
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // condition and read
  input  wire logic cond_i,
  input  wire logic read_i,
  output logic      flag_o
);

  localparam int unsigned CW = (FILTER > 1) ? $clog2(FILTER + 1) : 1;
  localparam logic [CW-1:0] LIMIT = CW'(FILTER);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          flag;
  logic          next_flag;
  logic          detect;

  // ----------------------------------------------------------------
  // filter and sticky flag
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    detect   = 1'b0;
    if (FILTER == 0) begin
      detect   = cond_i;
      next_cnt = '0;
    end else if (!cond_i) begin
      next_cnt = '0;
    end else if (cnt >= LIMIT) begin
      detect = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
    end
    next_flag = flag;
    if (detect) begin
      next_flag = 1'b1;
    end else if (read_i && !cond_i) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt  <= '0;
      flag <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      flag <= next_flag;
    end
  end

  assign flag_o = flag;

endmodule : rff_flag_cell

// ---- design/rff_top.sv ----
`timescale 1ns/10ps
// Function
// - aux regulator low flag sets after undervoltage lasts past the filter, clears on recovery plus read.
// - aux regulator overload flag sets after overcurrent lasts past the filter, clears on recovery plus read.
// - bus regulator thermal flag sets on over-temperature, clears when cool and read.
// - bus regulator undervoltage flag sets after the filter, clears when above threshold and read.
// - bus regulator overload flag sets after the filter, clears when current is low and read.
// - sense input low flag sets after the filter, clears when the pin recovers and is read.
// - primary supply low flag sets after the filter, clears on recovery plus read.
// - main regulator overload flag in normal mode only, filtered, clears on recovery plus read.
// - main regulator overload flag in low-power on mode, filtered, clears on recovery plus read.
// - main regulator thermal off flag sets on thermal shutdown, clears on recovery plus read.
// - short reset low flag sets on a reset low pulse under the limit, clears after it ends and read.
// - battery fail flag sets below the battery fail level, clears when above and read.
module rff_top #(
  parameter int unsigned FILTER_CYCLES    = rff_pkg::FILTER_CYCLES,
  parameter int unsigned RST_PULSE_CYCLES = rff_pkg::RST_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // comparator conditions, asynchronous, high while the fault is present
  input  wire logic aux_reg_undervolt_i,
  input  wire logic aux_reg_overcurrent_i,
  input  wire logic bus_reg_overtemp_i,
  input  wire logic bus_reg_undervolt_i,
  input  wire logic bus_reg_overcurrent_i,
  input  wire logic sense_input_low_i,
  input  wire logic primary_supply_low_i,
  input  wire logic main_reg_overcurrent_i,
  input  wire logic main_reg_lp_overcurrent_i,
  input  wire logic main_reg_thermal_off_i,
  input  wire logic reset_pin_low_i,
  input  wire logic battery_fail_i,
  // operating mode, same clock domain
  input  wire logic normal_mode_i,
  input  wire logic lowpower_main_on_i,
  // flag read strobe from the serial port, one cycle
  input  wire logic flag_read_i,
  // sticky flags
  output logic      aux_reg_low_flag_o,
  output logic      aux_reg_overload_flag_o,
  output logic      bus_reg_thermal_flag_o,
  output logic      bus_reg_undervolt_flag_o,
  output logic      bus_reg_overload_flag_o,
  output logic      sense_input_low_flag_o,
  output logic      primary_supply_low_flag_o,
  output logic      main_reg_overload_normal_flag_o,
  output logic      main_reg_overload_lowpower_flag_o,
  output logic      main_reg_thermal_off_flag_o,
  output logic      reset_short_low_flag_o,
  output logic      battery_fail_flag_o
);

  localparam int unsigned N = rff_pkg::FLAG_COUNT;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [N-1:0] raw;
  logic [N-1:0] syn;
  logic [N-1:0] cond;
  logic [N-1:0] flags;

  assign raw[rff_pkg::BIT_AUX_LOW]       = aux_reg_undervolt_i;
  assign raw[rff_pkg::BIT_AUX_OVERLOAD]  = aux_reg_overcurrent_i;
  assign raw[rff_pkg::BIT_BUS_THERMAL]   = bus_reg_overtemp_i;
  assign raw[rff_pkg::BIT_BUS_UNDERVOLT] = bus_reg_undervolt_i;
  assign raw[rff_pkg::BIT_BUS_OVERLOAD]  = bus_reg_overcurrent_i;
  assign raw[rff_pkg::BIT_SENSE_LOW]     = sense_input_low_i;
  assign raw[rff_pkg::BIT_SUPPLY_LOW]    = primary_supply_low_i;
  assign raw[rff_pkg::BIT_MAIN_OVL_NORM] = main_reg_overcurrent_i;
  assign raw[rff_pkg::BIT_MAIN_OVL_LP]   = main_reg_lp_overcurrent_i;
  assign raw[rff_pkg::BIT_MAIN_THERMAL]  = main_reg_thermal_off_i;
  assign raw[rff_pkg::BIT_RST_SHORT]     = reset_pin_low_i;
  assign raw[rff_pkg::BIT_BATTERY_FAIL]  = battery_fail_i;

  rff_sync #(
    .WIDTH (N)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (raw),
    .sync_o    (syn)
  );

  // ----------------------------------------------------------------
  // reset pin short pulse measurement
  // ----------------------------------------------------------------
  localparam int unsigned PW = $clog2(RST_PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PLIMIT = PW'(RST_PULSE_CYCLES);

  logic [PW-1:0] pulse_cnt;
  logic [PW-1:0] next_pulse_cnt;
  logic          pin_low_d;
  logic          next_pin_low_d;
  logic          short_seen;
  logic          pulse_end;

  always_comb begin
    next_pin_low_d = syn[rff_pkg::BIT_RST_SHORT];
    next_pulse_cnt = pulse_cnt;
    pulse_end      = pin_low_d && !syn[rff_pkg::BIT_RST_SHORT];
    short_seen     = pulse_end && (pulse_cnt < PLIMIT);
    if (syn[rff_pkg::BIT_RST_SHORT]) begin
      if (pulse_cnt < PLIMIT) begin
        next_pulse_cnt = pulse_cnt + PW'(1);
      end
    end else begin
      next_pulse_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_cnt <= '0;
      pin_low_d <= 1'b0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      pin_low_d <= next_pin_low_d;
    end
  end

  // ----------------------------------------------------------------
  // conditions seen by the flag cells
  // ----------------------------------------------------------------
  always_comb begin
    cond = syn;
    cond[rff_pkg::BIT_MAIN_OVL_NORM] = syn[rff_pkg::BIT_MAIN_OVL_NORM] && normal_mode_i;
    cond[rff_pkg::BIT_MAIN_OVL_LP]   = syn[rff_pkg::BIT_MAIN_OVL_LP] && lowpower_main_on_i;
    // set on a finished short pulse; cannot clear while the pin is still low
    cond[rff_pkg::BIT_RST_SHORT]     = short_seen || syn[rff_pkg::BIT_RST_SHORT];
  end

  // ----------------------------------------------------------------
  // flag cells: filtered ones, immediate ones and the reset short pulse flag
  // ----------------------------------------------------------------
  localparam logic [N-1:0] FILTERED = 12'h1FB;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      if (FILTERED[g]) begin : g_filt
        rff_flag_cell #(
          .FILTER (FILTER_CYCLES)
        ) u_cell (
          .ref_clk_i (ref_clk_i),
          .sys_rst_i (sys_rst_i),
          .cond_i    (cond[g]),
          .read_i    (flag_read_i),
          .flag_o    (flags[g])
        );
      end else if (g == rff_pkg::BIT_RST_SHORT) begin : g_pulse
        logic sflag;
        logic next_sflag;
        always_comb begin
          next_sflag = sflag;
          if (short_seen) begin
            next_sflag = 1'b1;
          end else if (flag_read_i && !cond[g]) begin
            next_sflag = 1'b0;
          end
        end
        always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
          if (sys_rst_i) begin
            sflag <= 1'b0;
          end else begin
            sflag <= next_sflag;
          end
        end
        assign flags[g] = sflag;
      end else begin : g_imm
        rff_flag_cell #(
          .FILTER (0)
        ) u_cell (
          .ref_clk_i (ref_clk_i),
          .sys_rst_i (sys_rst_i),
          .cond_i    (cond[g]),
          .read_i    (flag_read_i),
          .flag_o    (flags[g])
        );
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign aux_reg_low_flag_o                = flags[rff_pkg::BIT_AUX_LOW];
  assign aux_reg_overload_flag_o           = flags[rff_pkg::BIT_AUX_OVERLOAD];
  assign bus_reg_thermal_flag_o            = flags[rff_pkg::BIT_BUS_THERMAL];
  assign bus_reg_undervolt_flag_o          = flags[rff_pkg::BIT_BUS_UNDERVOLT];
  assign bus_reg_overload_flag_o           = flags[rff_pkg::BIT_BUS_OVERLOAD];
  assign sense_input_low_flag_o            = flags[rff_pkg::BIT_SENSE_LOW];
  assign primary_supply_low_flag_o         = flags[rff_pkg::BIT_SUPPLY_LOW];
  assign main_reg_overload_normal_flag_o   = flags[rff_pkg::BIT_MAIN_OVL_NORM];
  assign main_reg_overload_lowpower_flag_o = flags[rff_pkg::BIT_MAIN_OVL_LP];
  assign main_reg_thermal_off_flag_o       = flags[rff_pkg::BIT_MAIN_THERMAL];
  assign reset_short_low_flag_o            = flags[rff_pkg::BIT_RST_SHORT];
  assign battery_fail_flag_o               = flags[rff_pkg::BIT_BATTERY_FAIL];

endmodule : rff_top

// ---- test/rff_flags_properties.sv ----
`timescale 1ns/10ps
module rff_flags_checker #(
  parameter int unsigned FILTER_CYCLES = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // conditions and controls
  input wire logic aux_reg_undervolt_i,
  input wire logic bus_reg_overtemp_i,
  input wire logic main_reg_thermal_off_i,
  input wire logic battery_fail_i,
  input wire logic normal_mode_i,
  input wire logic flag_read_i,
  // flags
  input wire logic aux_reg_low_flag_o,
  input wire logic bus_reg_thermal_flag_o,
  input wire logic main_reg_overload_normal_flag_o,
  input wire logic main_reg_thermal_off_flag_o,
  input wire logic battery_fail_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_batt_held; battery_fail_i [*3]; endsequence
  sequence s_batt_gone; !battery_fail_i [*3]; endsequence
  property p_rst_zero; $fell(sys_rst_i) |-> !battery_fail_flag_o && !aux_reg_low_flag_o;
  endproperty
  property p_batt_set; battery_fail_i |-> ##3 battery_fail_flag_o; endproperty
  property p_thoff_set; main_reg_thermal_off_i |-> ##3 main_reg_thermal_off_flag_o; endproperty
  property p_bus_therm; bus_reg_overtemp_i ##1 bus_reg_overtemp_i |-> ##2 bus_reg_thermal_flag_o;
  endproperty
  property p_batt_hold; s_batt_held ##0 flag_read_i |=> battery_fail_flag_o; endproperty
  property p_batt_clear; s_batt_gone ##0 flag_read_i |=> !battery_fail_flag_o; endproperty
  property p_sticky; aux_reg_low_flag_o && !flag_read_i |=> aux_reg_low_flag_o; endproperty
  property p_filter;
    $rose(aux_reg_low_flag_o) |-> $past(aux_reg_undervolt_i, FILTER_CYCLES);
  endproperty
  property p_norm_mode; $rose(main_reg_overload_normal_flag_o) |-> $past(normal_mode_i);
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("flag set after reset");
  a_batt_set: assert property (p_batt_set) else $error("battery flag late");
  a_thoff_set: assert property (p_thoff_set) else $error("thermal off flag late");
  a_bus_therm: assert property (p_bus_therm) else $error("bus thermal flag late");
  a_batt_hold: assert property (p_batt_hold) else $error("flag cleared while present");
  a_batt_clear: assert property (p_batt_clear) else $error("flag not cleared");
  a_sticky: assert property (p_sticky) else $error("flag dropped without read");
  a_filter: assert property (p_filter) else $error("flag set before filter");
  a_norm_mode: assert property (p_norm_mode) else $error("flag set out of mode");
endmodule : rff_flags_checker
bind rff_top rff_flags_checker #(.FILTER_CYCLES(FILTER_CYCLES)) rff_flags_checker_inst (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .aux_reg_undervolt_i(aux_reg_undervolt_i),
  .bus_reg_overtemp_i(bus_reg_overtemp_i), .main_reg_thermal_off_i(main_reg_thermal_off_i),
  .battery_fail_i(battery_fail_i), .normal_mode_i(normal_mode_i), .flag_read_i(flag_read_i),
  .aux_reg_low_flag_o(aux_reg_low_flag_o), .bus_reg_thermal_flag_o(bus_reg_thermal_flag_o),
  .main_reg_overload_normal_flag_o(main_reg_overload_normal_flag_o),
  .main_reg_thermal_off_flag_o(main_reg_thermal_off_flag_o),
  .battery_fail_flag_o(battery_fail_flag_o));

// ---- test/rff_host_model.sv ----
`timescale 1ns/10ps
module rff_host_model (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // read request and strobe
  input  wire logic read_req_i,
  output logic      flag_read_o
);
  logic next_flag_read;
  always_comb begin
    next_flag_read = read_req_i;
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_read_o <= 1'b0;
    end else begin
      flag_read_o <= next_flag_read;
    end
  end
endmodule : rff_host_model

// ---- test/rff_tb.sv ----
`timescale 1ns/10ps
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  localparam int unsigned FILT = 8;
  localparam int unsigned RSTP = 50;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [11:0] cond      = 12'h000;
  logic [1:0]  mode      = 2'h3;
  logic        read_req  = 1'b0;
  logic        flag_read;
  wire  [11:0] flags;
  logic [11:0] exp_q[$];
  logic [11:0] exp_v;
  int          fails     = 0;
  int          cmp_count = 0;
  int          len;
  event        chk;
  always #5 ref_clk_i = ~ref_clk_i;
  rff_host_model rff_host_model_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .read_req_i(read_req), .flag_read_o(flag_read));
  rff_top #(.FILTER_CYCLES(FILT), .RST_PULSE_CYCLES(RSTP)) rff_top_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .aux_reg_undervolt_i(cond[0]),
    .aux_reg_overcurrent_i(cond[1]), .bus_reg_overtemp_i(cond[2]),
    .bus_reg_undervolt_i(cond[3]), .bus_reg_overcurrent_i(cond[4]),
    .sense_input_low_i(cond[5]), .primary_supply_low_i(cond[6]),
    .main_reg_overcurrent_i(cond[7]), .main_reg_lp_overcurrent_i(cond[8]),
    .main_reg_thermal_off_i(cond[9]), .reset_pin_low_i(cond[10]), .battery_fail_i(cond[11]),
    .normal_mode_i(mode[0]), .lowpower_main_on_i(mode[1]), .flag_read_i(flag_read),
    .aux_reg_low_flag_o(flags[0]), .aux_reg_overload_flag_o(flags[1]),
    .bus_reg_thermal_flag_o(flags[2]), .bus_reg_undervolt_flag_o(flags[3]),
    .bus_reg_overload_flag_o(flags[4]), .sense_input_low_flag_o(flags[5]),
    .primary_supply_low_flag_o(flags[6]), .main_reg_overload_normal_flag_o(flags[7]),
    .main_reg_overload_lowpower_flag_o(flags[8]), .main_reg_thermal_off_flag_o(flags[9]),
    .reset_short_low_flag_o(flags[10]), .battery_fail_flag_o(flags[11]));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc
  task automatic note(input logic [11:0] v);
    #1;
    exp_q.push_back(v);
    ->chk;
    @(posedge ref_clk_i);
  endtask : note
  task automatic rd();
    read_req <= 1'b1;
    cyc(1);
    read_req <= 1'b0;
    cyc(4);
  endtask : rd
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  always @(chk) begin
    exp_v = exp_q.pop_front();
    `CMP(flags, exp_v)
  end
  initial begin
    #200000;
    fails++;
    summarize();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    len = $urandom(32'h12A6);
    cyc(4);
    sys_rst_i <= 1'b0;
    cyc(2);
    note(12'h000);
    for (int i = 0; i < 12; i++) begin
      if (i == 10) continue;
      if ((12'h1FB & (12'h001 << i)) != 12'h000) begin
        len = $urandom_range(FILT - 1, 1);
        cond[i] <= 1'b1;
        cyc(len);
        cond[i] <= 1'b0;
        cyc(6);
        note(12'h000);
      end
      cond[i] <= 1'b1;
      cyc(FILT + 8);
      note(12'h001 << i);
      rd();
      note(12'h001 << i);
      cond[i] <= 1'b0;
      cyc(6);
      note(12'h001 << i);
      rd();
      note(12'h000);
      $display("test flag %0d done", i);
    end
    for (int j = 7; j < 9; j++) begin
      mode <= 2'h0;
      cond[j] <= 1'b1;
      cyc(FILT + 8);
      note(12'h000);
      cond[j] <= 1'b0;
      mode <= 2'h3;
      cyc(4);
    end
    $display("test mode gating done");
    len = $urandom_range(RSTP - 10, 2);
    cond[10] <= 1'b1;
    cyc(len);
    cond[10] <= 1'b0;
    cyc(4);
    note(12'h400);
    rd();
    note(12'h000);
    cond[10] <= 1'b1;
    cyc(RSTP + 10);
    cond[10] <= 1'b0;
    cyc(4);
    note(12'h000);
    $display("test reset pulse done");
    cond[11] <= 1'b1;
    cyc(5);
    sys_rst_i <= 1'b1;
    cyc(2);
    // drop the fault while reset still holds, so no check starts on a stale input
    cond[11] <= 1'b0;
    note(12'h000);
    sys_rst_i <= 1'b0;
    cyc(3);
    note(12'h000);
    $display("test mid reset done");
    summarize();
  end
endmodule : tb
